// ==== design/sqp_map.vh ====
`ifndef SQP_MAP_VH
`define SQP_MAP_VH

// Register byte offsets on the Avalon-MM slave.
`define SQP_OFF_CTRL 6'h00
`define SQP_OFF_PSTATE 6'h04
`define SQP_OFF_DEFPRI 6'h08
`define SQP_OFF_PRIMAP 6'h0c
`define SQP_OFF_DSCP0 6'h10
`define SQP_OFF_DSCP1 6'h14
`define SQP_OFF_DSCP2 6'h18
`define SQP_OFF_DSCP3 6'h1c
`define SQP_OFF_RATE 6'h20
`define SQP_OFF_BURST 6'h24
`define SQP_OFF_THRESH 6'h28
`define SQP_OFF_MULT 6'h2c
`define SQP_OFF_FLUSH 6'h30
`define SQP_OFF_STATUS 6'h34

// Control register field positions.
`define SQP_CTRL_IPSEL 0
`define SQP_CTRL_AWARE 1
`define SQP_CTRL_AVBEX 2
`define SQP_CTRL_EDEN 3
`define SQP_CTRL_HOST_LO 4
`define SQP_CTRL_HOST_HI 6
`define SQP_CTRL_WGT_LO 8
`define SQP_CTRL_WGT_HI 11

// Port state register field positions (one bit per port).
`define SQP_PS_TX_LO 0
`define SQP_PS_RX_LO 8
`define SQP_PS_LI_LO 16
`define SQP_PS_CE_LO 24

// Reset values.
`define SQP_RST_CTRL 32'h0000_0460
`define SQP_RST_PSTATE 32'h007f_0000
`define SQP_RST_DEFPRI 32'h0000_0000
`define SQP_RST_PRIMAP 32'h0000_fa50
`define SQP_RST_DSCP 32'h0000_0000
`define SQP_RST_RATE 32'h0100_0080
`define SQP_RST_BURST 32'h1000_0800
`define SQP_RST_THRESH 32'h8000_2000
`define SQP_RST_MULT 32'h0000_0020

// Colour codes.
`define SQP_GREEN 2'h0
`define SQP_YELLOW 2'h1
`define SQP_RED 2'h2

// Token buckets carry this many fraction bits.
`define SQP_FRAC 8

`endif

// ==== design/sqp_meter.v ====
`timescale 1ns/10ps
`default_nettype none
`include "sqp_map.vh"

module sqp_meter (
   input wire ref_clk, // Core clock.
   input wire rst, // Synchronous reset, active high.
   input wire [15:0] cir, // Committed rate, bytes per cycle with fraction bits.
   input wire [15:0] pir, // Peak rate, bytes per cycle with fraction bits.
   input wire [15:0] cbs, // Committed burst in bytes.
   input wire [15:0] pbs, // Peak burst in bytes.
   input wire aware, // Colour-aware mode.
   input wire chk, // Packet is metered this cycle.
   input wire [15:0] len, // Packet length in bytes.
   input wire [1:0] pre_col, // Colour given by an earlier stage.
   output reg [1:0] col // Colour for the packet in this cycle.
);

   reg [23:0] ctok_r;
   reg [23:0] ptok_r;
   wire [24:0] csum;
   wire [24:0] psum;
   wire [23:0] ccap;
   wire [23:0] pcap;
   wire [23:0] len_f;
   wire [23:0] cfill;
   wire [23:0] pfill;

   // Buckets refill every cycle and saturate at their burst sizes.
   assign len_f = {len, 8'h00};
   assign ccap = {cbs, 8'h00};
   assign pcap = {pbs, 8'h00};
   assign csum = {1'b0, ctok_r} + {9'h000, cir};
   assign psum = {1'b0, ptok_r} + {9'h000, pir};
   assign cfill = (csum > {1'b0, ccap}) ? ccap : csum[23:0];
   assign pfill = (psum > {1'b0, pcap}) ? pcap : psum[23:0];

   // Colour decision; aware mode never upgrades a pre-coloured packet.
   always @* begin
      col = `SQP_GREEN;
      if (pfill < len_f || (aware && pre_col == `SQP_RED)) begin
         col = `SQP_RED;
      end else if (cfill < len_f || (aware && pre_col == `SQP_YELLOW)) begin
         col = `SQP_YELLOW;
      end
   end

   // Red packets spend nothing; yellow spend peak only; green spend both.
   always @(posedge ref_clk) begin
      if (rst) begin
         ctok_r <= 24'h000000;
         ptok_r <= 24'h000000;
      end else begin
         ctok_r <= (chk && col == `SQP_GREEN) ? cfill - len_f : cfill;
         ptok_r <= (chk && col != `SQP_RED) ? pfill - len_f : pfill;
      end
   end

endmodule

`default_nettype wire

// ==== design/sqp_top.v ====
`timescale 1ns/10ps
`default_nettype none
`include "sqp_map.vh"

module sqp_top (
   input wire ref_clk, // Core clock, 125 MHz.
   input wire rst, // Synchronous reset, active high.
   // Avalon-MM slave.
   input wire [5:0] avs_address, // Byte address.
   input wire avs_read, // Read request.
   input wire avs_write, // Write request.
   input wire [31:0] avs_writedata, // Write data.
   input wire [3:0] avs_byteenable, // Byte lanes of a write.
   output reg [31:0] avs_readdata, // Read data.
   output wire avs_waitrequest, // Stall while high.
   // Frame request from the ingress parser.
   input wire req_valid, // One-cycle pulse per frame.
   input wire [2:0] req_port, // Ingress port index, 0 to 6.
   input wire req_tagged, // Frame carries a priority tag.
   input wire [2:0] req_pcp, // Tag priority field.
   input wire req_ip, // Frame carries an IP DSCP field.
   input wire [5:0] req_dscp, // DSCP value.
   input wire [1:0] req_color, // Pre-assigned colour.
   input wire [15:0] req_len, // Frame length in bytes.
   input wire req_avb, // Stream-reservation frame.
   input wire req_to_host, // Destined to the processor.
   input wire req_override, // Matched a static entry with override.
   input wire [6:0] req_egress, // Egress ports asked by lookup.
   input wire [15:0] mem_level, // Packet memory occupancy.
   input wire [15:0] tc_level, // Ingress queue depth of the frame's class.
   input wire [7:0] rnd_seed, // Added into the drop random source.
   // Decision, one cycle after the request.
   output reg res_valid, // One-cycle pulse.
   output reg [2:0] res_pcp, // Tag priority after the ceiling.
   output reg [1:0] res_queue, // Egress queue code.
   output reg [1:0] res_color, // Marked colour.
   output reg res_drop, // Frame is dropped.
   output reg res_learn, // Source address may be learned.
   output reg [6:0] res_egress, // Egress ports after state gating.
   output reg [6:0] flush_ports, // Ports whose table entries are to be flushed.
   output reg flush_valid // One-cycle pulse with flush_ports.
);

   localparam ST_IDLE = 1'b0;
   localparam ST_ACK = 1'b1;

   reg st_r;
   reg [31:0] ctrl_r;
   reg [31:0] pstate_r;
   reg [31:0] defpri_r;
   reg [31:0] primap_r;
   reg [31:0] dscp_r [0:3];
   reg [31:0] rate_r;
   reg [31:0] burst_r;
   reg [31:0] thresh_r;
   reg [31:0] mult_r;
   reg [15:0] avg_r;
   reg [15:0] drops_r;
   reg [15:0] lfsr_r;
   reg [31:0] rd_nxt;
   reg [31:0] wmask;
   reg [6:0] flush_mask_nxt;
   integer k;

   // Two-bit field of a packed table.
   function [1:0] get2;
      input [127:0] tbl;
      input [5:0] idx;
      begin
         get2 = tbl[{idx, 1'b0} +: 2];
      end
   endfunction

   // Three-bit per-port field.
   function [2:0] get3;
      input [31:0] tbl;
      input [2:0] idx;
      begin
         get3 = tbl[idx * 3 +: 3];
      end
   endfunction

   // Byte-lane merge of a write into an existing register.
   function [31:0] merge;
      input [31:0] old;
      input [31:0] wd;
      input [31:0] m;
      begin
         merge = (old & ~m) | (wd & m);
      end
   endfunction

   // Every access answers on its second cycle; the master sees one wait state.
   assign avs_waitrequest = (avs_read || avs_write) && st_r == ST_IDLE;

   always @* begin
      for (k = 0; k < 4; k = k + 1) begin
         wmask[k * 8 +: 8] = avs_byteenable[k] ? 8'hff : 8'h00;
      end
   end

   // Bus handshake state.
   always @(posedge ref_clk) begin
      if (rst) begin
         st_r <= ST_IDLE;
      end else begin
         case (st_r)
            ST_IDLE: begin
               if (avs_read || avs_write) begin
                  st_r <= ST_ACK;
               end
            end
            ST_ACK: begin
               st_r <= ST_IDLE;
            end
            default: begin
               st_r <= ST_IDLE;
            end
         endcase
      end
   end

   // Read mux; unmapped offsets read as zero.
   always @* begin
      case (avs_address)
         `SQP_OFF_CTRL: rd_nxt = ctrl_r;
         `SQP_OFF_PSTATE: rd_nxt = pstate_r;
         `SQP_OFF_DEFPRI: rd_nxt = defpri_r;
         `SQP_OFF_PRIMAP: rd_nxt = primap_r;
         `SQP_OFF_DSCP0: rd_nxt = dscp_r[0];
         `SQP_OFF_DSCP1: rd_nxt = dscp_r[1];
         `SQP_OFF_DSCP2: rd_nxt = dscp_r[2];
         `SQP_OFF_DSCP3: rd_nxt = dscp_r[3];
         `SQP_OFF_RATE: rd_nxt = rate_r;
         `SQP_OFF_BURST: rd_nxt = burst_r;
         `SQP_OFF_THRESH: rd_nxt = thresh_r;
         `SQP_OFF_MULT: rd_nxt = mult_r;
         `SQP_OFF_FLUSH: rd_nxt = {25'h0000000, pstate_r[`SQP_PS_LI_LO +: 7]};
         `SQP_OFF_STATUS: rd_nxt = {drops_r, avg_r};
         default: rd_nxt = 32'h00000000;
      endcase
   end

   always @(posedge ref_clk) begin
      if (rst) begin
         avs_readdata <= 32'h00000000;
      end else if (avs_read && st_r == ST_IDLE) begin
         avs_readdata <= rd_nxt;
      end
   end

   // Flush is honoured only for ports whose learning is inhibited.
   always @* begin
      flush_mask_nxt = avs_writedata[6:0] & pstate_r[`SQP_PS_LI_LO +: 7];
   end

   // Register writes take effect on the accepting edge.
   always @(posedge ref_clk) begin
      if (rst) begin
         ctrl_r <= `SQP_RST_CTRL;
         pstate_r <= `SQP_RST_PSTATE;
         defpri_r <= `SQP_RST_DEFPRI;
         primap_r <= `SQP_RST_PRIMAP;
         dscp_r[0] <= `SQP_RST_DSCP;
         dscp_r[1] <= `SQP_RST_DSCP;
         dscp_r[2] <= `SQP_RST_DSCP;
         dscp_r[3] <= `SQP_RST_DSCP;
         rate_r <= `SQP_RST_RATE;
         burst_r <= `SQP_RST_BURST;
         thresh_r <= `SQP_RST_THRESH;
         mult_r <= `SQP_RST_MULT;
         flush_ports <= 7'h00;
         flush_valid <= 1'b0;
      end else begin
         flush_valid <= 1'b0;
         if (avs_write && st_r == ST_ACK) begin
            case (avs_address)
               `SQP_OFF_CTRL: ctrl_r <= merge(ctrl_r, avs_writedata, wmask) & 32'h00000f7f;
               `SQP_OFF_PSTATE: pstate_r <= merge(pstate_r, avs_writedata, wmask) & 32'h7f7f7f7f;
               `SQP_OFF_DEFPRI: defpri_r <= merge(defpri_r, avs_writedata, wmask) & 32'h001fffff;
               `SQP_OFF_PRIMAP: primap_r <= merge(primap_r, avs_writedata, wmask) & 32'h0000ffff;
               `SQP_OFF_DSCP0: dscp_r[0] <= merge(dscp_r[0], avs_writedata, wmask);
               `SQP_OFF_DSCP1: dscp_r[1] <= merge(dscp_r[1], avs_writedata, wmask);
               `SQP_OFF_DSCP2: dscp_r[2] <= merge(dscp_r[2], avs_writedata, wmask);
               `SQP_OFF_DSCP3: dscp_r[3] <= merge(dscp_r[3], avs_writedata, wmask);
               `SQP_OFF_RATE: rate_r <= merge(rate_r, avs_writedata, wmask);
               `SQP_OFF_BURST: burst_r <= merge(burst_r, avs_writedata, wmask);
               `SQP_OFF_THRESH: thresh_r <= merge(thresh_r, avs_writedata, wmask);
               `SQP_OFF_MULT: mult_r <= merge(mult_r, avs_writedata, wmask) & 32'h000000ff;
               `SQP_OFF_FLUSH: begin
                  flush_ports <= flush_mask_nxt;
                  flush_valid <= avs_byteenable[0] && flush_mask_nxt != 7'h00;
               end
               default: begin
               end
            endcase
         end
      end
   end

   // Classification.
   wire [2:0] host_idx;
   wire [2:0] def_pri;
   wire ceil_en;
   wire [2:0] pcp_eff;
   wire [2:0] pri_src;
   wire [1:0] queue_nxt;
   wire is_host;

   assign host_idx = ctrl_r[`SQP_CTRL_HOST_HI:`SQP_CTRL_HOST_LO];
   assign is_host = req_port == host_idx;
   assign def_pri = get3(defpri_r, req_port);
   assign ceil_en = pstate_r[`SQP_PS_CE_LO + req_port];
   // Ceiling only lowers a priority that is numerically above the default.
   assign pcp_eff = (ceil_en && req_pcp > def_pri) ? def_pri : req_pcp;
   // Untagged frames fall back to the port default priority.
   assign pri_src = req_tagged ? pcp_eff : def_pri;
   assign queue_nxt = (ctrl_r[`SQP_CTRL_IPSEL] && req_ip) ?
                      get2({dscp_r[3], dscp_r[2], dscp_r[1], dscp_r[0]}, req_dscp) :
                      get2({112'h0, primap_r[15:0]}, {3'h0, pri_src});

   // Metering.
   wire [1:0] color_nxt;

   sqp_meter u_meter (
      .ref_clk(ref_clk),
      .rst(rst),
      .cir(rate_r[15:0]),
      .pir(rate_r[31:16]),
      .cbs(burst_r[15:0]),
      .pbs(burst_r[31:16]),
      .aware(ctrl_r[`SQP_CTRL_AWARE]),
      .chk(req_valid),
      .len(req_len),
      .pre_col(req_color),
      .col(color_nxt)
   );

   // Early drop: the deeper of the averaged memory level and the class queue is policed.
   wire [3:0] wgt;
   wire [15:0] min_th;
   wire [15:0] max_th;
   wire [15:0] depth;
   wire [15:0] span;
   wire [15:0] over;
   wire [23:0] lhs;
   wire [23:0] rhs;
   reg ed_drop;
   wire exempt;

   assign wgt = ctrl_r[`SQP_CTRL_WGT_HI:`SQP_CTRL_WGT_LO];
   assign min_th = thresh_r[15:0];
   assign max_th = thresh_r[31:16];
   assign depth = (avg_r > tc_level) ? avg_r : tc_level;
   assign span = max_th - min_th;
   assign over = depth - min_th;
   // Compare rnd*span with mult*over instead of dividing; mult is a fraction of 256.
   assign lhs = lfsr_r[7:0] * span;
   assign rhs = mult_r[7:0] * over;
   assign exempt = ctrl_r[`SQP_CTRL_AVBEX] && req_avb;

   always @* begin
      ed_drop = 1'b0;
      if (!ctrl_r[`SQP_CTRL_EDEN] || exempt || depth <= min_th) begin
         ed_drop = 1'b0;
      end else if (depth > max_th) begin
         ed_drop = 1'b1;
      end else begin
         ed_drop = lhs < rhs;
      end
   end

   // EWMA of memory occupancy, one step per frame request, dropped or not; a larger weight smooths more.
   always @(posedge ref_clk) begin
      if (rst) begin
         avg_r <= 16'h0000;
         lfsr_r <= 16'hace1;
         drops_r <= 16'h0000;
      end else begin
         lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]} ^ {8'h00, rnd_seed};
         if (req_valid) begin
            avg_r <= avg_r - (avg_r >> wgt) + (mem_level >> wgt);
            if (ed_drop) begin
               drops_r <= drops_r + 16'h0001;
            end
         end
      end
   end

   // Port state gating. Disabled, blocking, listening and discarding share bits 0,0,1,
   // so they act alike: only processor-bound override traffic leaves such a port, unless it is the host port.
   wire rx_en;
   wire learn_inh;
   wire [6:0] tx_en;
   wire rx_ok;

   assign rx_en = pstate_r[`SQP_PS_RX_LO + req_port];
   assign learn_inh = pstate_r[`SQP_PS_LI_LO + req_port];
   assign tx_en = pstate_r[`SQP_PS_TX_LO +: 7];
   assign rx_ok = is_host || rx_en || (req_to_host && req_override);

   always @(posedge ref_clk) begin
      if (rst) begin
         res_valid <= 1'b0;
         res_pcp <= 3'h0;
         res_queue <= 2'h0;
         res_color <= `SQP_GREEN;
         res_drop <= 1'b0;
         res_learn <= 1'b0;
         res_egress <= 7'h00;
      end else begin
         res_valid <= req_valid;
         if (req_valid) begin
            res_pcp <= pri_src;
            res_queue <= queue_nxt;
            res_color <= color_nxt;
            res_drop <= ed_drop || !rx_ok;
            res_learn <= !is_host && !learn_inh;
            // Host frames reach any port; others reach ports with transmit on plus the host, or only the host if receive is off.
            if (is_host) begin
               res_egress <= req_egress;
            end else if (rx_en) begin
               res_egress <= req_egress & (tx_en | (7'h01 << host_idx));
            end else begin
               res_egress <= req_egress & (7'h01 << host_idx);
            end
         end
      end
   end

endmodule

`default_nettype wire

// ==== testbench/sqp_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "sqp_map.vh"

// Port-level relations of the policy block; it sees nothing inside the design.
module sqp_checker (
   input wire logic ref_clk, // Core clock.
   input wire logic rst, // Synchronous reset.
   input wire logic [5:0] avs_address, // Byte address.
   input wire logic avs_read, // Read request.
   input wire logic avs_write, // Write request.
   input wire logic [31:0] avs_writedata, // Write data.
   input wire logic [3:0] avs_byteenable, // Write lanes.
   input wire logic [31:0] avs_readdata, // Read data.
   input wire logic avs_waitrequest, // Stall.
   input wire logic req_valid, // Frame request.
   input wire logic [6:0] req_egress, // Lookup egress mask.
   input wire logic res_valid, // Decision pulse.
   input wire logic [1:0] res_color, // Marked colour.
   input wire logic [6:0] res_egress, // Gated egress mask.
   input wire logic [6:0] flush_ports, // Flush mask.
   input wire logic flush_valid // Flush pulse.
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   // Accepted flush writes and their port mask, kept as plain signals for $past.
   wire flush_acc = avs_write && !avs_waitrequest && avs_address == `SQP_OFF_FLUSH && avs_byteenable[0];
   wire [6:0] wd_low = avs_writedata[6:0];

   // A bus request stalls for exactly one cycle before it is taken.
   sequence s_stall;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_accept;
      (avs_read || avs_write) && !avs_waitrequest;
   endsequence

   a_one_wait_state: assert property ($rose(avs_read || avs_write) |-> s_stall ##1 s_accept)
      else $error("bus request did not see exactly one wait state");
   a_read_hold: assert property (!avs_read |=> $stable(avs_readdata))
      else $error("read data changed without a read");
   a_answer_timing: assert property (res_valid == $past(req_valid))
      else $error("decision pulse not one cycle after the request");
   a_egress_subset: assert property (res_valid |-> (res_egress & ~$past(req_egress)) == 7'h00)
      else $error("gated egress mask added ports");
   a_colour_code: assert property (res_valid |-> res_color != 2'h3)
      else $error("colour code out of range");
   a_flush_cause: assert property (flush_valid |-> $past(flush_acc))
      else $error("flush pulse without a flush write");
   a_flush_mask: assert property (flush_valid |-> (flush_ports & ~$past(wd_low)) == 7'h00)
      else $error("flush mask wider than the written mask");
   a_flush_pulse: assert property (flush_valid |=> !flush_valid)
      else $error("flush pulse longer than one cycle");
endmodule

bind sqp_top sqp_checker u_sqp_checker (.ref_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
   .avs_byteenable, .avs_readdata, .avs_waitrequest, .req_valid, .req_egress, .res_valid, .res_color,
   .res_egress, .flush_ports, .flush_valid);

`default_nettype wire

// ==== testbench/sqp_fabric.sv ====
`timescale 1ns/10ps
`default_nettype none

// Ingress parser and lookup side: hands one frame request per call.
module sqp_fabric (
   input wire logic ref_clk, // Core clock.
   output var logic req_valid, // Frame request pulse.
   output var logic [2:0] req_port, // Ingress port.
   output var logic req_tagged, // Tagged frame.
   output var logic [2:0] req_pcp, // Tag priority.
   output var logic req_ip, // DSCP present.
   output var logic [5:0] req_dscp, // DSCP value.
   output var logic [1:0] req_color, // Pre-colour.
   output var logic [15:0] req_len, // Length in bytes.
   output var logic req_avb, // Stream-reservation frame.
   output var logic req_to_host, // Aimed at the processor.
   output var logic req_override, // Override static match.
   output var logic [6:0] req_egress, // Lookup egress mask.
   output var logic [15:0] mem_level, // Memory occupancy.
   output var logic [15:0] tc_level // Class queue depth.
);
   // Quiet at time zero; memory occupancy follows the class depth of each frame.
   initial begin
      {req_valid, req_port, req_tagged, req_pcp, req_ip, req_dscp, req_color} = '0;
      {req_len, req_avb, req_to_host, req_override, req_egress, mem_level, tc_level} = '0;
   end

   // Host-port frames are only aimed at ports in listening or later by the callers.
   task automatic send(input logic [2:0] p, input logic [4:0] f, input logic [2:0] pcp, input logic [5:0] ds,
                       input logic [1:0] col, input logic [15:0] len, input logic [6:0] eg, input logic [15:0] tc);
      @(posedge ref_clk);
      {req_port, req_pcp, req_dscp, req_color, req_len, req_egress, tc_level} <= {p, pcp, ds, col, len, eg, tc};
      {req_tagged, req_ip, req_avb, req_to_host, req_override} <= f;
      mem_level <= tc;
      req_valid <= 1'h1;
      @(posedge ref_clk);
      req_valid <= 1'h0;
      // Released fields are scrambled so that a late sample cannot match by luck.
      {req_pcp, req_dscp, req_len, req_egress} <= ~{pcp, ds, len, eg};
   endtask
endmodule

`default_nettype wire

// ==== testbench/sqp_top_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "sqp_map.vh"

module sqp_top_tb;
   localparam logic [4:0] f_tag = 5'h10;
   localparam logic [4:0] f_ip = 5'h08;
   localparam logic [4:0] f_avb = 5'h04;
   localparam logic [4:0] f_ovr = 5'h03;
   logic ref_clk = 1'h0;
   logic rst = 1'h1;
   logic [5:0] avs_address = 6'h00;
   logic avs_read = 1'h0;
   logic avs_write = 1'h0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'h0;
   logic [31:0] rdv;
   wire [31:0] avs_readdata;
   wire avs_waitrequest, req_valid, req_tagged, req_ip, req_avb, req_to_host, req_override;
   wire [2:0] req_port, req_pcp, res_pcp;
   wire [5:0] req_dscp;
   wire [1:0] req_color, res_queue, res_color;
   wire [15:0] req_len, mem_level, tc_level;
   wire [6:0] req_egress, res_egress, flush_ports;
   wire res_valid, res_drop, res_learn, flush_valid;
   int fails = 0;
   int check_count = 0;
   logic [5:0] ra [9] = '{`SQP_OFF_CTRL, `SQP_OFF_PSTATE, `SQP_OFF_DEFPRI, `SQP_OFF_PRIMAP, `SQP_OFF_DSCP0,
                          `SQP_OFF_RATE, `SQP_OFF_BURST, `SQP_OFF_THRESH, `SQP_OFF_MULT};
   logic [31:0] rv [9] = '{`SQP_RST_CTRL, `SQP_RST_PSTATE, `SQP_RST_DEFPRI, `SQP_RST_PRIMAP, `SQP_RST_DSCP,
                           `SQP_RST_RATE, `SQP_RST_BURST, `SQP_RST_THRESH, `SQP_RST_MULT};
   logic [31:0] dw [4] = '{32'he4e4_e4e4, 32'h1b1b_1b1b, 32'h9c9c_9c9c, 32'h3636_3636};

   // Free-running core clock, 8 ns period.
   always #4 ref_clk = ~ref_clk;

   sqp_top u_sqp_top (.ref_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
      .avs_readdata, .avs_waitrequest, .req_valid, .req_port, .req_tagged, .req_pcp, .req_ip, .req_dscp,
      .req_color, .req_len, .req_avb, .req_to_host, .req_override, .req_egress, .mem_level, .tc_level,
      .rnd_seed(8'h00), .res_valid, .res_pcp, .res_queue, .res_color, .res_drop, .res_learn, .res_egress,
      .flush_ports, .flush_valid);
   sqp_fabric u_fab (.ref_clk, .req_valid, .req_port, .req_tagged, .req_pcp, .req_ip, .req_dscp, .req_color,
      .req_len, .req_avb, .req_to_host, .req_override, .req_egress, .mem_level, .tc_level);

   // Prints the counts and the verdict, then stops the run.
   task automatic end_of_test;
      $display("Checks made %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("FAIL at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One Avalon access; only the watchdog ends a wait on a stuck slave.
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      if (wr) avs_write <= 1'h1;
      else avs_read <= 1'h1;
      do begin
         @(posedge ref_clk);
      end while (avs_waitrequest !== 1'h0);
      rdv = avs_readdata;
      avs_read <= 1'h0;
      avs_write <= 1'h0;
   endtask

   task automatic fr(input logic [2:0] p, input logic [4:0] f, input logic [2:0] pcp, input logic [5:0] ds,
                     input logic [1:0] col, input logic [15:0] len, input logic [6:0] eg, input logic [15:0] tc);
      u_fab.send(p, f, pcp, ds, col, len, eg, tc);
      #1;
      chk(res_valid, 32'h1);
   endtask

   task automatic t_regs;
      for (int i = 0; i < 9; i++) begin
         bus(1'h0, ra[i], 32'h0, 4'hf);
         chk(rdv, rv[i]);
      end
      bus(1'h1, 6'h38, 32'hffff_ffff, 4'hf);
      bus(1'h0, 6'h38, 32'h0, 4'hf);
      chk(rdv, 32'h0);
      // Only lane 0 lands; bits above the seven 3-bit fields stay clear.
      bus(1'h1, `SQP_OFF_DEFPRI, 32'hffff_ffff, 4'h1);
      bus(1'h0, `SQP_OFF_DEFPRI, 32'h0, 4'hf);
      chk(rdv, 32'hff);
   endtask

   task automatic t_prio;
      bus(1'h1, `SQP_OFF_PRIMAP, 32'h1be4, 4'hf);
      for (int i = 0; i < 8; i++) begin
         fr(3'h6, f_tag, i[2:0], 6'h0, 2'h0, 16'h40, 7'h01, 16'h0);
         chk(res_queue, (32'h1be4 >> (2 * i)) & 32'h3);
      end
      bus(1'h1, `SQP_OFF_DEFPRI, 32'h3, 4'hf);
      bus(1'h1, `SQP_OFF_PSTATE, 32'h0100_7f7f, 4'hf);
      for (int i = 0; i < 8; i++) begin
         fr(3'h0, f_tag, i[2:0], 6'h0, 2'h0, 16'h40, 7'h02, 16'h0);
         chk(res_pcp, (i > 3) ? 32'h3 : i);
      end
      bus(1'h1, `SQP_OFF_PSTATE, 32'h7f7f, 4'hf);
      fr(3'h0, f_tag, 3'h5, 6'h0, 2'h0, 16'h40, 7'h02, 16'h0);
      chk(res_pcp, 32'h5);
      bus(1'h1, `SQP_OFF_CTRL, 32'h461, 4'hf);
      for (int i = 0; i < 4; i++) bus(1'h1, `SQP_OFF_DSCP0 + 6'(4 * i), dw[i], 4'hf);
      for (int n = 0; n < 64; n++) begin
         fr(3'h6, f_ip, 3'h0, n[5:0], 2'h0, 16'h40, 7'h01, 16'h0);
         chk(res_queue, (dw[n / 16] >> (2 * (n % 16))) & 32'h3);
      end
   endtask

   // The buckets refill for 200 cycles, so each frame meets full buckets.
   task automatic met(input logic aware, input logic [1:0] pre, input logic [15:0] len, input logic [1:0] ec);
      bus(1'h1, `SQP_OFF_CTRL, aware ? 32'h462 : 32'h460, 4'hf);
      repeat (200) @(posedge ref_clk);
      fr(3'h6, 5'h0, 3'h0, 6'h0, pre, len, 7'h01, 16'h0);
      chk(res_color, ec);
   endtask

   task automatic ed(input logic [15:0] tc, input logic [7:0] m, input logic [4:0] f, input logic exp);
      bus(1'h1, `SQP_OFF_MULT, {24'h0, m}, 4'hf);
      repeat (4) begin
         fr(3'h6, f, 3'h0, 6'h0, 2'h0, 16'h40, 7'h01, tc);
         chk(res_drop, exp);
      end
   endtask

   // Port 0 takes the given state bits while ports 1 to 6 forward.
   task automatic pst(input logic t, input logic r, input logic l, input logic [4:0] f,
                      input logic edrop, input logic elearn, input logic [6:0] eeg);
      bus(1'h1, `SQP_OFF_PSTATE, 32'h7e7e | 32'(t) | (32'(r) << 8) | (32'(l) << 16), 4'hf);
      fr(3'h0, f, 3'h0, 6'h0, 2'h0, 16'h40, 7'h42, 16'h0);
      chk(res_drop, edrop);
      chk(res_learn, elearn);
      if (!edrop) chk(res_egress, eeg);
   endtask

   task automatic t_police;
      bus(1'h1, `SQP_OFF_RATE, 32'h0200_0100, 4'hf);
      bus(1'h1, `SQP_OFF_BURST, 32'h0080_0040, 4'hf);
      met(1'h0, `SQP_GREEN, 16'd200, `SQP_RED);
      met(1'h0, `SQP_GREEN, 16'd100, `SQP_YELLOW);
      met(1'h0, `SQP_GREEN, 16'd40, `SQP_GREEN);
      met(1'h0, `SQP_RED, 16'd40, `SQP_GREEN);
      met(1'h1, `SQP_RED, 16'd40, `SQP_RED);
      met(1'h1, `SQP_YELLOW, 16'd40, `SQP_YELLOW);
      met(1'h1, `SQP_GREEN, 16'd100, `SQP_YELLOW);
      bus(1'h1, `SQP_OFF_CTRL, 32'h468, 4'hf);
      ed(16'h1000, 8'hff, 5'h0, 1'h0);
      ed(16'h2000, 8'hff, 5'h0, 1'h0);
      ed(16'h8000, 8'h00, 5'h0, 1'h0);
      ed(16'h8001, 8'h00, 5'h0, 1'h1);
      bus(1'h1, `SQP_OFF_CTRL, 32'h46c, 4'hf);
      ed(16'h9000, 8'h00, f_avb, 1'h0);
      ed(16'h9000, 8'h00, 5'h0, 1'h1);
      bus(1'h0, `SQP_OFF_STATUS, 32'h0, 4'hf);
      chk(rdv[31:16], 32'h8);
      bus(1'h1, `SQP_OFF_CTRL, 32'h460, 4'hf);
   endtask

   task automatic t_state;
      pst(1'h1, 1'h1, 1'h0, 5'h0, 1'h0, 1'h1, 7'h42);
      pst(1'h1, 1'h1, 1'h0, f_ovr, 1'h0, 1'h1, 7'h42);
      pst(1'h0, 1'h0, 1'h0, 5'h0, 1'h1, 1'h1, 7'h00);
      pst(1'h0, 1'h0, 1'h0, f_ovr, 1'h0, 1'h1, 7'h40);
      pst(1'h0, 1'h0, 1'h1, 5'h0, 1'h1, 1'h0, 7'h00);
      pst(1'h0, 1'h0, 1'h1, f_ovr, 1'h0, 1'h0, 7'h40);
      // With port 0 as the tail-tag port its frames pass ungated.
      bus(1'h1, `SQP_OFF_CTRL, 32'h400, 4'hf);
      fr(3'h0, 5'h0, 3'h0, 6'h0, 2'h0, 16'h40, 7'h42, 16'h0);
      chk(res_drop, 32'h0);
      chk(res_egress, 32'h42);
      bus(1'h1, `SQP_OFF_CTRL, 32'h460, 4'hf);
      bus(1'h1, `SQP_OFF_PSTATE, 32'h0005_0000, 4'hf);
      bus(1'h1, `SQP_OFF_FLUSH, 32'h7f, 4'h1);
      #1;
      chk(flush_valid, 32'h1);
      chk(flush_ports, 32'h05);
      bus(1'h0, `SQP_OFF_FLUSH, 32'h0, 4'hf);
      chk(rdv, 32'h05);
      bus(1'h1, `SQP_OFF_FLUSH, 32'h7f, 4'h2);
      #1;
      chk(flush_valid, 32'h0);
   endtask

   // Main sequence: reset for 8 cycles, then each scenario in turn.
   initial begin
      repeat (8) @(posedge ref_clk);
      rst <= 1'h0;
      t_regs;
      t_prio;
      t_police;
      t_state;
      end_of_test;
   end

   // Watchdog well beyond the few thousand cycles the scenarios need.
   initial begin
      repeat (30000) @(posedge ref_clk);
      fails++;
      end_of_test;
   end
endmodule

`default_nettype wire
